// ### shared/mpt_defs.vh
// Constants for the motor PWM timer control block
`ifndef MPT_DEFS_VH
`define MPT_DEFS_VH

// Register byte offsets on the Wishbone bus
`define MPT_ADR_MODE       8'h00
`define MPT_ADR_CTRL0      8'h04
`define MPT_ADR_CTRL1      8'h08
`define MPT_ADR_EXTIRQ     8'h0c
`define MPT_ADR_COUNT      8'h10
`define MPT_ADR_PERIOD     8'h14
`define MPT_ADR_PERBUF     8'h18
`define MPT_ADR_PH0        8'h1c
`define MPT_ADR_PH1        8'h20
`define MPT_ADR_PH2        8'h24
`define MPT_ADR_PHB0       8'h28
`define MPT_ADR_PHB1       8'h2c
`define MPT_ADR_PHB2       8'h30
`define MPT_ADR_MPAT       8'h34
`define MPT_ADR_SPAT       8'h38
`define MPT_ADR_OLATCH     8'h3c

// Timer mode register fields
`define MPT_MODE_NMI_KILL  0
`define MPT_MODE_SOFT_KILL 1
`define MPT_MODE_ALV       2
`define MPT_MODE_PXFER     3
`define MPT_MODE_RESET     8'h00

// Timer control 0 fields
`define MPT_C0_CE          7
`define MPT_C0_DIR         5
`define MPT_C0_BXFER       4
`define MPT_C0_WMASK       8'hbf
`define MPT_C0_RESET       8'h00

// Timer control 1 fields
`define MPT_C1_CED         3
`define MPT_C1_WMASK       8'h8b
`define MPT_C1_RESET       8'h00

// External interrupt edge register
`define MPT_EI_NMI_RISE    0
`define MPT_EI_WMASK       8'hfd
`define MPT_EI_RESET       8'h00

// Decoded timer modes
`define MPT_M_INTERVAL     3'd0
`define MPT_M_TRI_SYM      3'd1
`define MPT_M_TRI_ASYM     3'd2
`define MPT_M_SAW          3'd3
`define MPT_M_PWM1         3'd4

// Valid NMI edge is held this many system clocks
`define MPT_NMI_HOLD_CLKS  5'd20

// Prescaler: five taps
`define MPT_PRE_DIV1       3'd0
`define MPT_PRE_DIV2       3'd1
`define MPT_PRE_DIV4       3'd2
`define MPT_PRE_DIV8       3'd3
`define MPT_PRE_DIV16      3'd4

`endif

// ### rtl/mpt_timer_ctrl.v
// Motor PWM timer control: mode decode, counter, reloads, output kill
//
// What this block does
// - Software kill bit set floats all six PWM pins, independent of NMI.
// - NMI kill enabled: valid NMI edge floats pins until bit cleared.
// - NMI valid edge held 20 clocks; late kill enable still catches it.
// - Active-level bit picks low/high active outputs in PWM mode 0 only.
// - Interval mode pattern transfer copies master to slave and latch on period match.
// - Mode bits decode to interval, two triangles, sawtooth, PWM mode 1.
// - Count, clear and compare reload points depend on mode.
// - Bit 6 of timer control 0 always reads zero.
// - Count direction flag is read only, cleared when counter stops.
// - Period buffer copy point depends on mode and transfer enable.
// - PWM mode 0 without dead time gives true and inverted pairs.
// - External interrupt edge register bit 1 always reads zero.
// - Reset clears control registers and clears, stops the counter.
// - Counter enable starts counting; clearing it zeroes and stops it.
// - Counter clock chosen among five prescaled clocks.
// - Down count reaching zero raises underflow event.
// - Interval mode: match flags event, clears next clock, period cmp+1.
// - Interval pattern transfer drives the six pins unmodified.
// - Mode register resets to zero: enabled, low active, interval.
`timescale 1ns/1ps
`include "mpt_defs.vh"

module mpt_timer_ctrl (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        nmi_pin,
	input  wire [5:0]  pin_function_ctrl,
	output reg  [5:0]  pwm_out,
	output reg  [5:0]  pwm_oe,
	output reg         period_match_irq,
	output reg         underflow_irq,
	output reg         nmi_valid_edge
);

	reg  [7:0]  timer_mode_reg;
	reg  [7:0]  timer_control_0;
	reg  [7:0]  timer_control_1;
	reg  [7:0]  ext_irq_edge_reg;
	reg  [15:0] main_counter;
	reg  [15:0] period_compare;
	reg  [15:0] period_buffer;
	reg  [15:0] phase_compare [0:2];
	reg  [15:0] phase_compare_buffer [0:2];
	reg  [5:0]  master_pattern_buffer;
	reg  [5:0]  slave_pattern_buffer;
	reg  [5:0]  output_latch;
	reg  [2:0]  phase_ff;
	reg         count_down;
	reg         pm_hold;
	reg  [3:0]  prescale;
	reg         nmi_meta;
	reg         nmi_sync;
	reg         nmi_prev;
	reg  [4:0]  nmi_hold;
	reg         nmi_killed;
	reg  [2:0]  mode;
	reg         tick;
	reg  [15:0] next_count;
	reg         next_down;
	reg         pm_evt;
	reg         uf_evt;
	reg  [5:0]  next_pins;
	reg  [31:0] rd_data;

	wire       counter_enable = timer_control_0[`MPT_C0_CE];
	wire       period_buffer_xfer_en = timer_control_0[`MPT_C0_BXFER];
	wire [2:0] clock_select = timer_control_0[2:0];
	wire       deadtime_enable = timer_control_1[`MPT_C1_CED];
	wire       nmi_output_kill_en = timer_mode_reg[`MPT_MODE_NMI_KILL];
	wire       soft_output_kill = timer_mode_reg[`MPT_MODE_SOFT_KILL];
	wire       output_active_level = timer_mode_reg[`MPT_MODE_ALV];
	wire       pattern_transfer_en = timer_mode_reg[`MPT_MODE_PXFER];
	wire       pattern_select = timer_mode_reg[7];
	wire       mode_bit2 = timer_mode_reg[6];
	wire       mode_bit1 = timer_mode_reg[5];
	wire       mode_bit0 = timer_mode_reg[4];
	wire       bus_req = wb_cyc_i & wb_stb_i;
	wire       bus_wr = bus_req & wb_we_i & wb_ack_o;
	wire       is_pwm0 = (mode == `MPT_M_TRI_SYM) |
			(mode == `MPT_M_TRI_ASYM) | (mode == `MPT_M_SAW);
	wire       is_tri = (mode == `MPT_M_TRI_SYM) |
			(mode == `MPT_M_TRI_ASYM);
	wire       nmi_edge = ext_irq_edge_reg[`MPT_EI_NMI_RISE] ?
			(nmi_sync & ~nmi_prev) : (~nmi_sync & nmi_prev);
	wire       kill_all = soft_output_kill | nmi_killed;

	// Mode decode
	always @* begin
		if (!mode_bit2)
			mode = `MPT_M_INTERVAL;
		else if (pattern_select)
			mode = `MPT_M_PWM1;
		else if (mode_bit1)
			mode = `MPT_M_SAW;
		else if (mode_bit0)
			mode = `MPT_M_TRI_ASYM;
		else
			mode = `MPT_M_TRI_SYM;
	end

	// Count clock enable from the free running prescaler
	always @* begin
		case (clock_select)
		`MPT_PRE_DIV1: tick = 1'b1;
		`MPT_PRE_DIV2: tick = prescale[0];
		`MPT_PRE_DIV4: tick = &prescale[1:0];
		`MPT_PRE_DIV8: tick = &prescale[2:0];
		default:       tick = &prescale;
		endcase
	end

	// Next count value, direction and timer events
	always @* begin
		next_count = main_counter;
		next_down = count_down;
		pm_evt = 1'b0;
		uf_evt = 1'b0;
		if (counter_enable && tick) begin
			if (is_tri) begin
				if (!count_down) begin
					if (main_counter == period_compare) begin
						next_down = 1'b1;
						next_count = main_counter - 16'h0001;
						pm_evt = 1'b1;
					end else begin
						next_count = main_counter + 16'h0001;
					end
				end else begin
					next_count = main_counter - 16'h0001;
					if (next_count == 16'h0000) begin
						uf_evt = 1'b1;
						next_down = 1'b0;
					end
				end
			end else begin
				// Match is held: a compare reloaded on it must not skip the clear
				if (pm_hold)
					next_count = 16'h0000;
				else
					next_count = main_counter + 16'h0001;
				pm_evt = (next_count == period_compare);
			end
		end
	end

	// Prescaler, counter and direction
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 4'h0;
			main_counter <= 16'h0000;
			count_down <= 1'b0;
			pm_hold <= 1'b0;
		end else begin
			prescale <= prescale + 4'h1;
			pm_hold <= counter_enable && (tick ? (pm_evt && !is_tri) : pm_hold);
			if (!counter_enable) begin
				main_counter <= 16'h0000;
				count_down <= 1'b0;
			end else begin
				main_counter <= next_count;
				count_down <= next_down;
			end
		end
	end

	// Period compare: direct write or buffered reload
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			period_compare <= 16'hffff;
			period_buffer <= 16'hffff;
		end else begin
			if (bus_wr && wb_adr_i == `MPT_ADR_PERIOD)
				period_compare <= wb_dat_i[15:0];
			else if (period_buffer_xfer_en && mode != `MPT_M_INTERVAL &&
					((is_tri && uf_evt) || (!is_tri && pm_evt)))
				period_compare <= period_buffer;
			if (bus_wr && wb_adr_i == `MPT_ADR_PERBUF)
				period_buffer <= wb_dat_i[15:0];
		end
	end

	// Phase compares and their buffers, one per channel
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_phase
			wire reload = (is_tri && uf_evt) ||
				(mode == `MPT_M_TRI_ASYM && pm_evt) ||
				((mode == `MPT_M_SAW || mode == `MPT_M_PWM1) && pm_evt);
			wire hit = counter_enable && tick &&
				(main_counter == phase_compare[g]);
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					phase_compare[g] <= 16'hffff;
					phase_compare_buffer[g] <= 16'hffff;
					phase_ff[g] <= 1'b0;
				end else begin
					if (reload)
						phase_compare[g] <= phase_compare_buffer[g];
					else if (bus_wr &&
							wb_adr_i == `MPT_ADR_PH0 + 8'h04 * g)
						phase_compare[g] <= wb_dat_i[15:0];
					if (bus_wr && wb_adr_i == `MPT_ADR_PHB0 + 8'h04 * g)
						phase_compare_buffer[g] <= wb_dat_i[15:0];
					if (!counter_enable)
						phase_ff[g] <= 1'b0;
					else if (is_tri && hit)
						phase_ff[g] <= ~count_down;
					else if (mode == `MPT_M_SAW && hit)
						phase_ff[g] <= 1'b1;
					else if (mode == `MPT_M_SAW && pm_evt)
						phase_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Pattern buffers and output latch
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master_pattern_buffer <= 6'h00;
			slave_pattern_buffer <= 6'h00;
			output_latch <= 6'h00;
		end else begin
			if (bus_wr && wb_adr_i == `MPT_ADR_MPAT)
				master_pattern_buffer <= wb_dat_i[5:0];
			if (mode == `MPT_M_INTERVAL && pattern_transfer_en &&
					pm_evt) begin
				slave_pattern_buffer <= master_pattern_buffer;
				output_latch <= master_pattern_buffer;
			end else if (mode == `MPT_M_PWM1 && pm_evt) begin
				slave_pattern_buffer <= master_pattern_buffer;
			end else if (mode == `MPT_M_PWM1 && counter_enable && tick &&
					main_counter == phase_compare[0]) begin
				output_latch <= slave_pattern_buffer;
			end else if (bus_wr && wb_adr_i == `MPT_ADR_OLATCH &&
					(mode == `MPT_M_INTERVAL || mode == `MPT_M_PWM1)) begin
				// Latch is write protected in PWM mode 0
				output_latch <= wb_dat_i[5:0];
			end
		end
	end

	// NMI pin synchroniser, edge detect and hold stretch
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_meta <= 1'b0;
			nmi_sync <= 1'b0;
			nmi_prev <= 1'b0;
			nmi_hold <= 5'd0;
			nmi_valid_edge <= 1'b0;
			nmi_killed <= 1'b0;
		end else begin
			nmi_meta <= nmi_pin;
			nmi_sync <= nmi_meta;
			nmi_prev <= nmi_sync;
			if (nmi_edge)
				nmi_hold <= `MPT_NMI_HOLD_CLKS;
			else if (nmi_hold != 5'd0)
				nmi_hold <= nmi_hold - 5'd1;
			nmi_valid_edge <= nmi_edge || (nmi_hold > 5'd1);
			// Stays set after the hold ends until the enable drops
			nmi_killed <= nmi_output_kill_en &&
				(nmi_killed || nmi_valid_edge);
		end
	end

	// Pin level selection per mode
	always @* begin
		if (is_pwm0) begin
			// Dead time shaping is outside this block: pairs stay complementary
			next_pins[0] = ~(phase_ff[0] ^ output_active_level);
			next_pins[1] = ~(~phase_ff[0] ^ output_active_level);
			next_pins[2] = ~(phase_ff[1] ^ output_active_level);
			next_pins[3] = ~(~phase_ff[1] ^ output_active_level);
			next_pins[4] = ~(phase_ff[2] ^ output_active_level);
			next_pins[5] = ~(~phase_ff[2] ^ output_active_level);
		end else begin
			next_pins = output_latch;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out <= 6'h00;
			pwm_oe <= 6'h00;
			period_match_irq <= 1'b0;
			underflow_irq <= 1'b0;
		end else begin
			pwm_out <= next_pins;
			pwm_oe <= kill_all ? 6'h00 : pin_function_ctrl;
			period_match_irq <= pm_evt;
			underflow_irq <= uf_evt;
		end
	end

	// Read mux
	always @* begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
		`MPT_ADR_MODE:   rd_data[7:0] = timer_mode_reg;
		`MPT_ADR_CTRL0:  rd_data[7:0] = {timer_control_0[7], 1'b0,
				count_down, timer_control_0[4:0]};
		`MPT_ADR_CTRL1:  rd_data[7:0] = timer_control_1;
		`MPT_ADR_EXTIRQ: rd_data[7:0] = ext_irq_edge_reg;
		`MPT_ADR_COUNT:  rd_data[15:0] = main_counter;
		`MPT_ADR_PERIOD: rd_data[15:0] = period_compare;
		`MPT_ADR_PERBUF: rd_data[15:0] = period_buffer;
		`MPT_ADR_PH0:    rd_data[15:0] = phase_compare[0];
		`MPT_ADR_PH1:    rd_data[15:0] = phase_compare[1];
		`MPT_ADR_PH2:    rd_data[15:0] = phase_compare[2];
		`MPT_ADR_PHB0:   rd_data[15:0] = phase_compare_buffer[0];
		`MPT_ADR_PHB1:   rd_data[15:0] = phase_compare_buffer[1];
		`MPT_ADR_PHB2:   rd_data[15:0] = phase_compare_buffer[2];
		`MPT_ADR_MPAT:   rd_data[5:0] = master_pattern_buffer;
		`MPT_ADR_SPAT:   rd_data[5:0] = slave_pattern_buffer;
		`MPT_ADR_OLATCH: rd_data[5:0] = output_latch;
		default:         rd_data = 32'h0000_0000;
		endcase
	end

	// Wishbone slave and control registers; writes land on the ack edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			timer_mode_reg <= `MPT_MODE_RESET;
			timer_control_0 <= `MPT_C0_RESET;
			timer_control_1 <= `MPT_C1_RESET;
			ext_irq_edge_reg <= `MPT_EI_RESET;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req && !wb_ack_o)
				wb_dat_o <= rd_data;
			// Writes while running are taken as is
			if (bus_wr && wb_sel_i[0]) begin
				case (wb_adr_i)
				`MPT_ADR_MODE:
					timer_mode_reg <= wb_dat_i[7:0];
				`MPT_ADR_CTRL0:
					timer_control_0 <= wb_dat_i[7:0] &
						`MPT_C0_WMASK;
				`MPT_ADR_CTRL1:
					timer_control_1 <= wb_dat_i[7:0] & `MPT_C1_WMASK;
				`MPT_ADR_EXTIRQ:
					ext_irq_edge_reg <= wb_dat_i[7:0] &
						`MPT_EI_WMASK;
				default: ;
				endcase
			end
		end
	end


endmodule // mpt_timer_ctrl

// ### rtl/mpt_unused_placeholder_never.v
// Intentionally empty design note file
`timescale 1ns/1ps

// ### testbench/mpt_monitor.sv
// Port checker for the motor PWM timer control block
`timescale 1ns/1ps
`include "mpt_defs.vh"
module mpt_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [5:0]  pwm_out,
	input wire logic [5:0]  pwm_oe,
	input wire logic        nmi_valid_edge
);
	logic [7:0] mode_q;
	logic [7:0] c0_q;
	logic [4:0] hold;
	wire        wr = wb_ack_o && wb_we_i && wb_sel_i[0];
	wire        rd = wb_ack_o && !wb_we_i;
	// Shadow copies of the bits whose effect shows at the pins or in register reads
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 8'h00;
			c0_q <= 8'h00;
			hold <= 5'h00;
		end else begin
			if (wr && wb_adr_i == `MPT_ADR_MODE)
				mode_q <= wb_dat_i[7:0];
			if (wr && wb_adr_i == `MPT_ADR_CTRL0)
				c0_q <= wb_dat_i[7:0];
			hold <= nmi_valid_edge ? hold + 5'h01 : 5'h00;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("request not answered next cycle");
	a_c0_bit6: assert property (rd && wb_adr_i == `MPT_ADR_CTRL0
		|-> wb_dat_o[6] == 1'b0) else $error("ctrl0 bit 6 read as one");
	a_ei_bit1: assert property (rd && wb_adr_i == `MPT_ADR_EXTIRQ
		|-> wb_dat_o[1] == 1'b0) else $error("edge reg bit 1 read as one");
	a_dir_clear: assert property (rd && wb_adr_i == `MPT_ADR_CTRL0
		&& !c0_q[7] |-> !wb_dat_o[5]) else $error("direction set while stopped");
	a_count_stop: assert property (rd && wb_adr_i == `MPT_ADR_COUNT
		&& !c0_q[7] |-> wb_dat_o[15:0] == 16'h0000)
		else $error("stopped counter not zero");
	a_nmi_hold: assert property ($fell(nmi_valid_edge)
		|-> hold == `MPT_NMI_HOLD_CLKS) else $error("edge signal width wrong");
	a_nmi_kill: assert property (nmi_valid_edge && mode_q[0]
		|-> ##2 pwm_oe == 6'h00) else $error("nmi did not float outputs");
	a_soft_kill: assert property (mode_q[1] && $past(mode_q[1])
		|-> pwm_oe == 6'h00) else $error("soft kill left outputs driven");
	a_pair_compl: assert property (mode_q[6] && !mode_q[7]
		|=> (pwm_out[0] ^ pwm_out[1]) && (pwm_out[2] ^ pwm_out[3]) &&
		(pwm_out[4] ^ pwm_out[5])) else $error("pin pair not complementary");
endmodule // mpt_monitor

bind mpt_timer_ctrl mpt_monitor i_mon (.clk(clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_out(pwm_out),
	.pwm_oe(pwm_oe),
	.nmi_valid_edge(nmi_valid_edge));

// ### testbench/mpt_stage_model.sv
// Inverter power stage seen through its six gate inputs
`timescale 1ns/1ps
module mpt_stage_model (
	input  wire logic       clk,
	input  wire logic [5:0] pwm_out,
	input  wire logic [5:0] pwm_oe,
	output logic [5:0]      gate
);
	logic [5:0] last = 6'h00;
	// No pulls: a floating pin shows the inverse of its last driven level
	always @(posedge clk)
		last <= (pwm_oe & pwm_out) | (~pwm_oe & last);
	assign gate = (pwm_oe & pwm_out) | (~pwm_oe & ~last);
endmodule // mpt_stage_model

// ### testbench/tb_top.sv
// Self-checking bench for the motor PWM timer control block
`timescale 1ns/1ps
`include "mpt_defs.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic        nmi = 1'b0;
	logic [5:0]  pfc = 6'h00;
	logic [31:0] rdat;
	logic        ack;
	logic [5:0]  pout;
	logic [5:0]  poe;
	logic        pm_irq;
	logic        uf_irq;
	logic        nve;
	logic [5:0]  gate;
	logic [7:0]  md [6] = '{8'h00, 8'h80, 8'h40, 8'h54, 8'h60, 8'hc0};
	int          err_total = 0;
	int          checks_done = 0;
	always #5 clk = ~clk;
	mpt_timer_ctrl i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .nmi_pin(nmi),
		.pin_function_ctrl(pfc), .pwm_out(pout), .pwm_oe(poe),
		.period_match_irq(pm_irq), .underflow_irq(uf_irq),
		.nmi_valid_edge(nve));
	mpt_stage_model i_stage (.clk(clk), .pwm_out(pout), .pwm_oe(poe),
		.gate(gate));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	task automatic gap(input bit uf, output int g);
		int n;
		n = 0;
		while ((uf ? uf_irq : pm_irq) !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while ((uf ? uf_irq : pm_irq) !== 1'b1 && g < 2000);
	endtask
	task automatic waitn(input logic v);
		int n;
		n = 0;
		while (nve !== v && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Mode bits only change with the counter stopped
	task automatic run(input logic [7:0] m, input logic [7:0] c0,
		input logic [15:0] p1, input logic [15:0] p2, input bit uf,
		input int e);
		int g;
		wr(`MPT_ADR_CTRL0, 32'h0);
		wr(`MPT_ADR_MODE, {24'h0, m});
		wr(`MPT_ADR_PERIOD, {16'h0, p1});
		wr(`MPT_ADR_PERBUF, {16'h0, p2});
		wr(`MPT_ADR_CTRL0, {24'h0, c0 | 8'h80});
		gap(uf, g);
		chk("event spacing", e, g);
		wr(`MPT_ADR_CTRL0, {24'h0, c0});
		rd(`MPT_ADR_COUNT, 32'h0, "stopped count");
		rd(`MPT_ADR_CTRL0, {24'h0, c0 & 8'h1f}, "ctrl0");
		if (m[6] && !m[7])
			chk("idle pins", {26'h0, m[2] ? 6'h2a : 6'h15}, {26'h0, pout});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		close_out();
	end
	initial begin
		logic [15:0] p1;
		logic [15:0] p2;
		logic [5:0]  pat;
		bit          uf;
		int          e;
		void'($urandom(32'h4c49996c));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(`MPT_ADR_MODE, 32'h0, "mode reset");
		rd(`MPT_ADR_CTRL0, 32'h0, "ctrl0 reset");
		rd(`MPT_ADR_CTRL1, 32'h0, "ctrl1 reset");
		rd(`MPT_ADR_EXTIRQ, 32'h0, "edge reset");
		rd(`MPT_ADR_COUNT, 32'h0, "count reset");
		wr(`MPT_ADR_CTRL0, 32'h4f);
		rd(`MPT_ADR_CTRL0, 32'h0f, "ctrl0 bit6");
		wr(`MPT_ADR_EXTIRQ, 32'hff);
		rd(`MPT_ADR_EXTIRQ, 32'hfd, "edge bit1");
		wr(`MPT_ADR_CTRL1, 32'hff);
		rd(`MPT_ADR_CTRL1, 32'h8b, "ctrl1 mask");
		wr(`MPT_ADR_CTRL1, 32'h0);
		rd(8'hfc, 32'h0, "unmapped");
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			p1 = 16'd2 + 16'($urandom % 8);
			p2 = 16'd2 + 16'($urandom % 8);
			uf = (i == 2 || i == 3);
			e = (i < 2) ? p1 + 1 : uf ? 2 * p2 : p2 + 1;
			run(md[i], 8'h10, p1, p2, uf, e);
		end
		$display("test modes done");
		for (int d = 0; d < 5; d++) begin
			p1 = 16'd1 + 16'($urandom % 6);
			run(8'h00, 8'(d), p1, p1, 1'b0, (p1 + 1) << d);
		end
		$display("test prescaler done");
		pfc <= 6'h3f;
		pat = 6'($urandom);
		wr(`MPT_ADR_MPAT, {26'h0, pat});
		wr(`MPT_ADR_MODE, 32'h08);
		wr(`MPT_ADR_PERIOD, 32'h3);
		wr(`MPT_ADR_CTRL0, 32'h80);
		gap(1'b0, e);
		repeat (3) @(posedge clk);
		chk("pattern pins", {26'h0, pat}, {26'h0, pout});
		chk("stage gates", {26'h0, pat}, {26'h0, gate});
		rd(`MPT_ADR_SPAT, {26'h0, pat}, "slave pattern");
		chk("pins driven", 32'h3f, {26'h0, poe});
		wr(`MPT_ADR_MODE, 32'h0a);
		repeat (2) @(posedge clk);
		chk("soft kill", 32'h0, {26'h0, poe});
		wr(`MPT_ADR_MODE, 32'h08);
		wr(`MPT_ADR_EXTIRQ, 32'h01);
		nmi <= 1'b1;
		waitn(1'b1);
		wr(`MPT_ADR_MODE, 32'h09);
		waitn(1'b0);
		repeat (3) @(posedge clk);
		chk("nmi kill held", 32'h0, {26'h0, poe});
		wr(`MPT_ADR_MODE, 32'h08);
		repeat (3) @(posedge clk);
		chk("kill released", 32'h3f, {26'h0, poe});
		nmi <= 1'b0;
		$display("test outputs done");
		close_out();
	end
endmodule // tb_top
